/* File: rtcyp_params.svh */
// Register offsets, field positions and reset values of the year, prescale and interrupt block
`ifndef RTCYP_PARAMS_SVH
`define RTCYP_PARAMS_SVH

`define RTCYP_ADDR_W 8
`define RTCYP_DATA_W 32

`define RTCYP_OFF_YEAR_VALUE 8'h0c
`define RTCYP_OFF_YEAR_MATCH 8'h10
`define RTCYP_OFF_YEAR_LOAD 8'h14
`define RTCYP_OFF_PRESCALE 8'h18
`define RTCYP_OFF_IRQ_MASK 8'h1c
`define RTCYP_OFF_IRQ_RAW 8'h20
`define RTCYP_OFF_IRQ_MASKED 8'h24
`define RTCYP_OFF_IRQ_CLEAR 8'h28

`define RTCYP_YEAR_W 14
`define RTCYP_YEAR_RST 14'h2000
`define RTCYP_MATCH_RST 14'h2000
`define RTCYP_PRESET_RST 14'h0000

`define RTCYP_DIV_LSB 0
`define RTCYP_DIV_W 15
`define RTCYP_DIV_RST 15'h7fff
`define RTCYP_TRIM_LSB 16
`define RTCYP_TRIM_W 10
`define RTCYP_TRIM_RST 10'h000
`define RTCYP_LOCK_BIT 26

// Trim window is 1023 slow cycles: counts 0 to 1022
`define RTCYP_TRIM_LAST 10'h3fe

`define RTCYP_IRQ_CAL 0
`define RTCYP_IRQ_CNT 1
`define RTCYP_IRQ_W 2

`endif

/* File: rtcyp_pkg.sv */
// Types shared by the year, prescale and interrupt block
`include "rtcyp_params.svh"

package rtcyp_pkg;

  typedef struct packed {
    logic sec;
    logic timer;
  } rtcyp_tick_t;

  typedef struct packed {
    logic [`RTCYP_DIV_W-1:0] div_cnt;
    logic [`RTCYP_TRIM_W-1:0] win_cnt;
    logic [`RTCYP_TRIM_W-1:0] del_cnt;
    rtcyp_tick_t tick;
  } rtcyp_presc_state_t;

  typedef struct packed {
    logic [1:0] sync;
    logic slow_prev;
    logic [`RTCYP_YEAR_W-1:0] year_now;
    logic [`RTCYP_YEAR_W-1:0] year_compare;
    logic [`RTCYP_YEAR_W-1:0] year_preset;
    logic [`RTCYP_DIV_W-1:0] divider;
    logic [`RTCYP_TRIM_W-1:0] trim;
    logic lock;
    logic [`RTCYP_IRQ_W-1:0] irq_en;
    logic [`RTCYP_IRQ_W-1:0] irq_raw;
    logic [`RTCYP_DATA_W-1:0] rd_data;
  } rtcyp_state_t;

endpackage

/* File: rtcyp_prescaler.sv */
// Slow clock divider with trim deletion, producing second and timer ticks
`timescale 1ns/1ps
`include "rtcyp_params.svh"

module rtcyp_prescaler
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic slow_tick_i,
  input wire logic [`RTCYP_DIV_W-1:0] divider_i,
  input wire logic [`RTCYP_TRIM_W-1:0] trim_i,
  output rtcyp_pkg::rtcyp_tick_t tick_o
);

  rtcyp_pkg::rtcyp_presc_state_t s_r;
  rtcyp_pkg::rtcyp_presc_state_t s_nxt;

  always_comb
  begin
    logic deleted;
    deleted = 1'b0;
    s_nxt = s_r;
    s_nxt.tick.sec = 1'b0;
    s_nxt.tick.timer = 1'b0;
    if (slow_tick_i)
    begin
      // Deleted pulses are the first ones of each window
      deleted = (s_r.del_cnt < trim_i);
      if (s_r.win_cnt == `RTCYP_TRIM_LAST)
      begin
        s_nxt.win_cnt = '0;
        s_nxt.del_cnt = '0;
      end
      else
      begin
        s_nxt.win_cnt = s_r.win_cnt + 10'h001;
        if (deleted)
        begin
          s_nxt.del_cnt = s_r.del_cnt + 10'h001;
        end
      end
      if (divider_i == '0)
      begin
        // Timer runs at the slow rate, clockwatch stands still
        s_nxt.div_cnt = '0;
        s_nxt.tick.timer = 1'b1;
      end
      else if (!deleted)
      begin
        // Counter may exceed a divider lowered on the fly; restart then
        if (s_r.div_cnt >= divider_i)
        begin
          s_nxt.div_cnt = '0;
          s_nxt.tick.sec = 1'b1;
          s_nxt.tick.timer = 1'b1;
        end
        else
        begin
          s_nxt.div_cnt = s_r.div_cnt + 15'h0001;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign tick_o = s_r.tick;

endmodule

/* File: rtcyp_top.sv */
// Year registers, prescale control with enable lock, and interrupt status of the clock unit
// What this block does
// - Read-only BCD year, resets to 2000
// - Writable BCD year match, resets to 2000
// - Writable BCD year load, resets to zero
// - Second tick every divider plus one cycles
// - Divider zero: timer slow rate, clockwatch stopped
// - Delete trim count pulses per 1023 cycles
// - Enable bit starts clockwatch, reads back stored
// - After enable, prescale control writes ignored
// - Mask bit 0 enables clockwatch interrupt
// - Mask bit 1 enables timer interrupt
// - Raw status: clockwatch bit 0, timer bit 1
// - Masked status is raw AND enable
// - Clear register: one clears, zero no effect
`timescale 1ns/1ps
`include "rtcyp_params.svh"

module rtcyp_top
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [`RTCYP_ADDR_W-1:0] addr_i,
  input wire logic [`RTCYP_DATA_W-1:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [`RTCYP_DATA_W-1:0] rd_data_o,
  input wire logic slow_clock_i,
  input wire logic year_carry_i,
  input wire logic calendar_event_i,
  input wire logic countdown_event_i,
  output logic calendar_enable_o,
  output logic second_tick_o,
  output logic countdown_tick_o,
  output logic year_match_o,
  output logic calendar_irq_out_o,
  output logic countdown_irq_out_o,
  output logic irq_o
);

  rtcyp_pkg::rtcyp_state_t s_r;
  rtcyp_pkg::rtcyp_state_t s_nxt;
  rtcyp_pkg::rtcyp_tick_t tick;
  logic slow_tick;
  logic [`RTCYP_IRQ_W-1:0] irq_masked;

  // Four BCD digits, top digit two bits wide; wraps after 3999
  function automatic logic [`RTCYP_YEAR_W-1:0] rtcyp_bcd_inc(
    input logic [`RTCYP_YEAR_W-1:0] y
  );
    logic [3:0] d0;
    logic [3:0] d1;
    logic [3:0] d2;
    logic [1:0] d3;
    d0 = y[3:0];
    d1 = y[7:4];
    d2 = y[11:8];
    d3 = y[13:12];
    if (d0 != 4'h9)
    begin
      d0 = d0 + 4'h1;
    end
    else
    begin
      d0 = 4'h0;
      if (d1 != 4'h9)
      begin
        d1 = d1 + 4'h1;
      end
      else
      begin
        d1 = 4'h0;
        if (d2 != 4'h9)
        begin
          d2 = d2 + 4'h1;
        end
        else
        begin
          d2 = 4'h0;
          d3 = d3 + 2'h1;
        end
      end
    end
    return {d3, d2, d1, d0};
  endfunction

  // Pad a year field into a bus word, upper bits reserved as zero
  function automatic logic [`RTCYP_DATA_W-1:0] rtcyp_year_word(
    input logic [`RTCYP_YEAR_W-1:0] y
  );
    return {{(`RTCYP_DATA_W-`RTCYP_YEAR_W){1'b0}}, y};
  endfunction

  // Slow clock pin is asynchronous; first stage feeds only the second
  assign slow_tick = s_r.sync[1] & ~s_r.slow_prev;

  assign irq_masked = s_r.irq_raw & s_r.irq_en;

  always_comb
  begin
    logic [`RTCYP_IRQ_W-1:0] clr;
    logic [`RTCYP_IRQ_W-1:0] evt;
    clr = '0;
    evt = '0;
    s_nxt = s_r;
    s_nxt.sync = {s_r.sync[0], slow_clock_i};
    s_nxt.slow_prev = s_r.sync[1];
    s_nxt.rd_data = '0;

    // The year moves only while the clockwatch runs
    if (s_r.lock && year_carry_i)
    begin
      s_nxt.year_now = rtcyp_bcd_inc(s_r.year_now);
    end

    if (wr_en_i)
    begin
      case (addr_i)
        `RTCYP_OFF_YEAR_MATCH:
        begin
          s_nxt.year_compare = wr_data_i[`RTCYP_YEAR_W-1:0];
        end
        `RTCYP_OFF_YEAR_LOAD:
        begin
          // Loading wins over a carry in the same cycle
          s_nxt.year_preset = wr_data_i[`RTCYP_YEAR_W-1:0];
          s_nxt.year_now = wr_data_i[`RTCYP_YEAR_W-1:0];
        end
        `RTCYP_OFF_PRESCALE:
        begin
          if (!s_r.lock)
          begin
            s_nxt.divider = wr_data_i[`RTCYP_DIV_LSB +: `RTCYP_DIV_W];
            s_nxt.trim = wr_data_i[`RTCYP_TRIM_LSB +: `RTCYP_TRIM_W];
            s_nxt.lock = wr_data_i[`RTCYP_LOCK_BIT];
          end
        end
        `RTCYP_OFF_IRQ_MASK:
        begin
          s_nxt.irq_en[`RTCYP_IRQ_CAL] = wr_data_i[`RTCYP_IRQ_CAL];
          s_nxt.irq_en[`RTCYP_IRQ_CNT] = wr_data_i[`RTCYP_IRQ_CNT];
        end
        `RTCYP_OFF_IRQ_CLEAR:
        begin
          clr = wr_data_i[`RTCYP_IRQ_W-1:0];
        end
        default:
        begin
          clr = '0;
        end
      endcase
    end

    evt[`RTCYP_IRQ_CAL] = calendar_event_i;
    evt[`RTCYP_IRQ_CNT] = countdown_event_i;
    // Set wins over a clear in the same cycle so no event is lost
    s_nxt.irq_raw = (s_r.irq_raw & ~clr) | evt;

    if (rd_en_i)
    begin
      case (addr_i)
        `RTCYP_OFF_YEAR_VALUE:
        begin
          s_nxt.rd_data = rtcyp_year_word(s_r.year_now);
        end
        `RTCYP_OFF_YEAR_MATCH:
        begin
          s_nxt.rd_data = rtcyp_year_word(s_r.year_compare);
        end
        `RTCYP_OFF_YEAR_LOAD:
        begin
          s_nxt.rd_data = rtcyp_year_word(s_r.year_preset);
        end
        `RTCYP_OFF_PRESCALE:
        begin
          s_nxt.rd_data[`RTCYP_DIV_LSB +: `RTCYP_DIV_W] = s_r.divider;
          s_nxt.rd_data[`RTCYP_TRIM_LSB +: `RTCYP_TRIM_W] = s_r.trim;
          s_nxt.rd_data[`RTCYP_LOCK_BIT] = s_r.lock;
        end
        `RTCYP_OFF_IRQ_MASK:
        begin
          s_nxt.rd_data[`RTCYP_IRQ_W-1:0] = s_r.irq_en;
        end
        `RTCYP_OFF_IRQ_RAW:
        begin
          s_nxt.rd_data[`RTCYP_IRQ_W-1:0] = s_r.irq_raw;
        end
        `RTCYP_OFF_IRQ_MASKED:
        begin
          s_nxt.rd_data[`RTCYP_IRQ_W-1:0] = irq_masked;
        end
        default:
        begin
          s_nxt.rd_data = '0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_r.sync <= '0;
      s_r.slow_prev <= 1'b0;
      s_r.year_now <= `RTCYP_YEAR_RST;
      s_r.year_compare <= `RTCYP_MATCH_RST;
      s_r.year_preset <= `RTCYP_PRESET_RST;
      s_r.divider <= `RTCYP_DIV_RST;
      s_r.trim <= `RTCYP_TRIM_RST;
      s_r.lock <= 1'b0;
      s_r.irq_en <= '0;
      s_r.irq_raw <= '0;
      s_r.rd_data <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  rtcyp_prescaler u_prescaler
  (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .slow_tick_i(slow_tick),
    .divider_i(s_r.divider),
    .trim_i(s_r.trim),
    .tick_o(tick)
  );

  assign rd_data_o = s_r.rd_data;
  assign calendar_enable_o = s_r.lock;
  // Clockwatch tick withheld until enabled; timer tick runs regardless
  assign second_tick_o = tick.sec & s_r.lock;
  assign countdown_tick_o = tick.timer;
  assign year_match_o = (s_r.year_now == s_r.year_compare);
  assign calendar_irq_out_o = irq_masked[`RTCYP_IRQ_CAL];
  assign countdown_irq_out_o = irq_masked[`RTCYP_IRQ_CNT];
  assign irq_o = |irq_masked;

endmodule

/* File: rtcyp_chk.sv */
// Port-level assertions for the year, prescale and interrupt block
`timescale 1ns/1ps
`include "rtcyp_params.svh"
module rtcyp_chk
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [`RTCYP_ADDR_W-1:0] addr_i,
  input wire logic [`RTCYP_DATA_W-1:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic calendar_event_i,
  input wire logic countdown_event_i,
  input wire logic calendar_enable_o,
  input wire logic second_tick_o,
  input wire logic calendar_irq_out_o,
  input wire logic countdown_irq_out_o,
  input wire logic irq_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic wm = wr_en_i && addr_i == `RTCYP_OFF_IRQ_MASK;
  wire logic wc = wr_en_i && addr_i == `RTCYP_OFF_IRQ_CLEAR;
  AST_IRQ_OR: assert property (irq_o == (calendar_irq_out_o | countdown_irq_out_o))
    else $error("combined irq differs from its two sources");
  AST_CAL_OFF: assert property (wm && !wr_data_i[0] |=> !calendar_irq_out_o)
    else $error("clockwatch irq high with its enable cleared");
  AST_CNT_OFF: assert property (wm && !wr_data_i[1] |=> !countdown_irq_out_o)
    else $error("timer irq high with its enable cleared");
  // Bench calls leave one idle cycle between them; the timer event is the second call
  AST_CAL_ON: assert property (wm && wr_data_i[0] ##1 !wm ##1 calendar_event_i && !wm
    |=> calendar_irq_out_o)
    else $error("clockwatch event did not raise enabled irq");
  AST_CNT_ON: assert property (wm && wr_data_i[1] ##1 (!wm)[*3] ##1 countdown_event_i
    && !wm |=> countdown_irq_out_o)
    else $error("timer event did not raise enabled irq");
  AST_CLR: assert property (wc && wr_data_i[0] && !calendar_event_i
    |=> !calendar_irq_out_o)
    else $error("clockwatch irq survived a clear");
  AST_STICKY: assert property (calendar_irq_out_o && !wc && !wm |=> calendar_irq_out_o)
    else $error("clockwatch irq dropped without a clear");
  AST_LOCK: assert property (calendar_enable_o |=> calendar_enable_o)
    else $error("enable lock dropped before reset");
  AST_TICK_EN: assert property (second_tick_o |-> calendar_enable_o)
    else $error("second tick while clockwatch disabled");
  COV_CAL: cover property (calendar_event_i ##1 calendar_irq_out_o);
  COV_CLR: cover property (wc && wr_data_i[1]);
  COV_TICK: cover property (second_tick_o);
endmodule
bind rtcyp_top rtcyp_chk u_chk (.ref_clk_i, .rst_n_i, .addr_i, .wr_data_i, .wr_en_i,
  .calendar_event_i, .countdown_event_i, .calendar_enable_o, .second_tick_o,
  .calendar_irq_out_o, .countdown_irq_out_o, .irq_o);

/* File: rtc_year_prescale_irq_tb_top.sv */
// Register-level testbench for the year, prescale and interrupt block
`timescale 1ns/1ps
`include "rtcyp_params.svh"
module rtc_year_prescale_irq_tb_top;
  logic ref_clk_i, rst_n_i, wr_en_i, rd_en_i, slow_clock_i;
  logic year_carry_i, calendar_event_i, countdown_event_i;
  logic [7:0] addr_i;
  logic [31:0] wr_data_i, rd_data_o;
  logic calendar_enable_o, second_tick_o, countdown_tick_o, year_match_o;
  logic calendar_irq_out_o, countdown_irq_out_o, irq_o;
  int n_fail = 0;
  int total_checks = 0;
  int n_sec, n_cnt;
  logic [7:0] ra [9] = '{8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h30};
  logic [31:0] rv [9] = '{32'h2000, 32'h2000, 32'h0, 32'h7fff, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0};
  rtcyp_top dut (.ref_clk_i, .rst_n_i, .addr_i, .wr_data_i, .wr_en_i, .rd_en_i, .rd_data_o,
    .slow_clock_i, .year_carry_i, .calendar_event_i, .countdown_event_i, .calendar_enable_o,
    .second_tick_o, .countdown_tick_o, .year_match_o, .calendar_irq_out_o,
    .countdown_irq_out_o, .irq_o);
  initial
  begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // Unrelated to the bus clock on purpose, so the synchroniser is exercised
  initial
  begin
    slow_clock_i = 1'b0;
    forever #60.5 slow_clock_i = ~slow_clock_i;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_en_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_en_i <= 1'b0;
    #1;
    chk($sformatf("reg_%h", a), rd_data_o, exp);
  endtask
  task automatic ev(input int k);
    @(posedge ref_clk_i);
    calendar_event_i <= (k == 0);
    countdown_event_i <= (k == 1);
    year_carry_i <= (k == 2);
    @(posedge ref_clk_i);
    {calendar_event_i, countdown_event_i, year_carry_i} <= 3'h0;
  endtask
  // 968 cycles cover 64 slow periods
  task automatic count_ticks();
    n_sec = 0;
    n_cnt = 0;
    repeat (968)
    begin
      @(posedge ref_clk_i);
      #1;
      n_sec += int'(second_tick_o);
      n_cnt += int'(countdown_tick_o);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    {rst_n_i, wr_en_i, rd_en_i, year_carry_i, calendar_event_i, countdown_event_i} = 6'h0;
    addr_i = 8'h00;
    wr_data_i = 32'h0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 9; i++)
      rd(ra[i], rv[i]);
    wr(8'h0c, 32'h1234);
    rd(8'h0c, 32'h2000);
    wr(8'h10, 32'hffffffff);
    rd(8'h10, 32'h3fff);
    $display("test registers done");
    wr(8'h1c, 32'h3);
    ev(0);
    ev(1);
    rd(8'h20, 32'h3);
    rd(8'h24, 32'h3);
    chk("irq_o", irq_o, 1'b1);
    wr(8'h1c, 32'h1);
    rd(8'h24, 32'h1);
    chk("countdown_irq", countdown_irq_out_o, 1'b0);
    wr(8'h28, 32'h0);
    rd(8'h20, 32'h3);
    wr(8'h28, 32'h1);
    rd(8'h20, 32'h2);
    chk("calendar_irq", calendar_irq_out_o, 1'b0);
    wr(8'h28, 32'h2);
    rd(8'h20, 32'h0);
    $display("test interrupts done");
    wr(8'h18, 32'h0);
    count_ticks();
    chk("cnt_ticks_div0", 32'(n_cnt >= 63 && n_cnt <= 65), 32'h1);
    chk("sec_ticks_div0", 32'(n_sec), 32'h0);
    // Trim of 16 owed in the current window: about 48 of 64 edges count
    wr(8'h18, 32'h00100001);
    count_ticks();
    chk("cnt_ticks_trim", 32'(n_cnt >= 22 && n_cnt <= 26), 32'h1);
    chk("sec_ticks_unlocked", 32'(n_sec), 32'h0);
    wr(8'h18, 32'h04000001);
    rd(8'h18, 32'h04000001);
    chk("enable", calendar_enable_o, 1'b1);
    wr(8'h18, 32'h00030000);
    rd(8'h18, 32'h04000001);
    count_ticks();
    chk("sec_ticks_div1", 32'(n_sec >= 31 && n_sec <= 33), 32'h1);
    $display("test prescale done");
    wr(8'h10, 32'h2000);
    wr(8'h14, 32'h1999);
    rd(8'h14, 32'h1999);
    rd(8'h0c, 32'h1999);
    chk("year_match_off", year_match_o, 1'b0);
    ev(2);
    rd(8'h0c, 32'h2000);
    chk("year_match_on", year_match_o, 1'b1);
    $display("test year done");
    // Only a reset releases the enable lock
    rst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rd(8'h18, 32'h7fff);
    chk("enable_after_reset", calendar_enable_o, 1'b0);
    wr(8'h18, 32'h00000003);
    rd(8'h18, 32'h00000003);
    rd(8'h0c, 32'h2000);
    $display("test reset done");
    close_out();
  end
endmodule
